// ===== include/bsf_defs.svh
`ifndef BSF_DEFS_SVH
`define BSF_DEFS_SVH

// register byte offsets
`define BSF_OFS_STATUS 8'h00
`define BSF_OFS_WORK 8'h04
`define BSF_OFS_IO 8'h08
`define BSF_OFS_CMD 8'h0c

// reset values
`define BSF_RST_STATUS 8'h00
`define BSF_RST_WORK 8'h00
`define BSF_RST_IO 8'h00

// command register fields
`define BSF_CMD_OP_LSB 0
`define BSF_CMD_BIT_LSB 8
`define BSF_CMD_BUSY_POS 16

// status flag positions
`define BSF_FLAG_C 0
`define BSF_FLAG_Z 1
`define BSF_FLAG_N 2
`define BSF_FLAG_V 3
`define BSF_FLAG_S 4
`define BSF_FLAG_H 5
`define BSF_FLAG_T 6
`define BSF_FLAG_I 7

// execution cycle counts
`define BSF_IO_OP_CYCLES 2
`define BSF_REG_OP_CYCLES 1

// bus responses
`define BSF_RESP_OKAY 2'b00
`define BSF_RESP_SLVERR 2'b10

`endif

// ===== include/bsf_pkg.sv
package bsf_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_IO_BIT_SET = 5'h01,
        OP_IO_BIT_CLEAR = 5'h02,
        OP_LOGICAL_LEFT_SHIFT = 5'h03,
        OP_LOGICAL_RIGHT_SHIFT = 5'h04,
        OP_ROTATE_LEFT_CARRY = 5'h05,
        OP_ROTATE_RIGHT_CARRY = 5'h06,
        OP_ARITH_RIGHT_SHIFT = 5'h07,
        OP_NIBBLE_SWAP = 5'h08,
        OP_BIT_TO_TRANSFER = 5'h09,
        OP_TRANSFER_TO_BIT = 5'h0a,
        OP_INDEXED_FLAG_SET = 5'h0b,
        OP_INDEXED_FLAG_CLEAR = 5'h0c,
        OP_CARRY_SET = 5'h10,
        OP_ZERO_SET = 5'h11,
        OP_NEGATIVE_SET = 5'h12,
        OP_OVERFLOW_SET = 5'h13,
        OP_SIGNED_SET = 5'h14,
        OP_HALF_CARRY_SET = 5'h15,
        OP_TRANSFER_SET = 5'h16,
        OP_IRQ_ENABLE = 5'h17,
        OP_CARRY_CLEAR = 5'h18,
        OP_ZERO_CLEAR = 5'h19,
        OP_NEGATIVE_CLEAR = 5'h1a,
        OP_OVERFLOW_CLEAR = 5'h1b,
        OP_SIGNED_CLEAR = 5'h1c,
        OP_HALF_CARRY_CLEAR = 5'h1d,
        OP_TRANSFER_CLEAR = 5'h1e,
        OP_IRQ_DISABLE = 5'h1f
    } bsf_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } bsf_state_t;

endpackage : bsf_pkg

// ===== include/bsf_alu_if.sv
`timescale 1ns/1ps

interface bsf_alu_if;
    bsf_pkg::bsf_op_t op;
    logic [7:0] operand;
    logic [2:0] bitSel;
    logic [7:0] flagsIn;
    logic [7:0] result;
    logic [7:0] flagsOut;

    modport ctrl (output op, output operand, output bitSel, output flagsIn, input result, input flagsOut);
    modport alu (input op, input operand, input bitSel, input flagsIn, output result, output flagsOut);
endinterface : bsf_alu_if

// ===== verilog/bsf_alu.sv
`timescale 1ns/1ps
`include "bsf_defs.svh"

module bsf_alu (
    bsf_alu_if.alu port // operation in, result and flags out
);
    logic [7:0] res;
    logic [7:0] fl;
    logic shiftFlags;
    logic newCarry;

    always_comb
    begin
        res = port.operand;
        fl = port.flagsIn;
        shiftFlags = 1'b0;
        newCarry = port.flagsIn[`BSF_FLAG_C];
        unique case (port.op)
            bsf_pkg::OP_IO_BIT_SET: res[port.bitSel] = 1'b1;
            bsf_pkg::OP_IO_BIT_CLEAR: res[port.bitSel] = 1'b0;
            bsf_pkg::OP_LOGICAL_LEFT_SHIFT:
            begin
                res = {port.operand[6:0], 1'b0};
                newCarry = port.operand[7];
                shiftFlags = 1'b1;
            end
            bsf_pkg::OP_LOGICAL_RIGHT_SHIFT:
            begin
                res = {1'b0, port.operand[7:1]};
                newCarry = port.operand[0];
                shiftFlags = 1'b1;
            end
            bsf_pkg::OP_ROTATE_LEFT_CARRY:
            begin
                res = {port.operand[6:0], port.flagsIn[`BSF_FLAG_C]};
                newCarry = port.operand[7];
                shiftFlags = 1'b1;
            end
            bsf_pkg::OP_ROTATE_RIGHT_CARRY:
            begin
                res = {port.flagsIn[`BSF_FLAG_C], port.operand[7:1]};
                newCarry = port.operand[0];
                shiftFlags = 1'b1;
            end
            bsf_pkg::OP_ARITH_RIGHT_SHIFT:
            begin
                res = {port.operand[7], port.operand[7:1]};
                newCarry = port.operand[0];
                shiftFlags = 1'b1;
            end
            bsf_pkg::OP_NIBBLE_SWAP: res = {port.operand[3:0], port.operand[7:4]};
            bsf_pkg::OP_BIT_TO_TRANSFER: fl[`BSF_FLAG_T] = port.operand[port.bitSel];
            bsf_pkg::OP_TRANSFER_TO_BIT: res[port.bitSel] = port.flagsIn[`BSF_FLAG_T];
            bsf_pkg::OP_INDEXED_FLAG_SET: fl[port.bitSel] = 1'b1;
            bsf_pkg::OP_INDEXED_FLAG_CLEAR: fl[port.bitSel] = 1'b0;
            default:
            begin
                // dedicated flag ops: low 3 bits name the flag, bit 3 means clear
                if (port.op[4])
                begin
                    fl[port.op[2:0]] = ~port.op[3];
                end
            end
        endcase
        if (shiftFlags)
        begin
            fl[`BSF_FLAG_C] = newCarry;
            fl[`BSF_FLAG_Z] = (res == 8'h00);
            fl[`BSF_FLAG_N] = res[7];
            fl[`BSF_FLAG_V] = res[7] ^ newCarry;
        end
    end

    assign port.result = res;
    assign port.flagsOut = fl;
endmodule : bsf_alu

// ===== verilog/bsf_unit.sv
// Function
// - io_bit_set_op sets chosen I/O bit, keeps others and flags, takes 2 cycles.
// - io_bit_clear_op clears chosen I/O bit, keeps others and flags, takes 2 cycles.
// - logical_left_shift_op shifts up, zero into bit 0, updates Z C N V, 1 cycle.
// - logical right shift shifts down, zero into bit 7, updates Z C N V, 1 cycle.
// - rotate_left_carry_op: old carry into bit 0, bit 7 to carry, 1 cycle.
// - rotate right through carry: old carry into bit 7, bit 0 to carry, 1 cycle.
// - arith_right_shift_op shifts bits 7..1 down, bit 7 kept, updates Z C N V.
// - nibble swap exchanges register halves in one cycle, flags untouched.
// - bit_to_transfer_op copies register bit into transfer flag only, 1 cycle.
// - transfer_to_bit_op copies transfer flag into register bit only, 1 cycle.
// - every flag settable in one cycle, dedicated or indexed, others unchanged.
// - every flag clearable in one cycle, dedicated or indexed, others unchanged.
`timescale 1ns/1ps
`include "bsf_defs.svh"

module bsf_unit (
    input wire logic clk, // core clock
    input wire logic reset_n, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [7:0] statusFlags, // status_flags_register contents
    output logic busy // instruction in flight
);
    bsf_alu_if aluBus ();

    bsf_pkg::bsf_state_t state;
    bsf_pkg::bsf_op_t curOp;
    logic [2:0] curBit;
    logic cycLeft;
    logic [7:0] work;
    logic [7:0] ioReg;
    logic [7:0] flagReg;

    logic [7:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic writeFire;
    logic writeOk;
    logic cmdStart;
    logic isIoCmd;
    logic commit;
    logic curIsIo;
    bsf_pkg::bsf_op_t cmdOp;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    bsf_alu alu (
        .port(aluBus.alu)
    );

    // write channel capture, either order
    assign s_axi_awready = ce && !awHeld && !s_axi_bvalid;
    assign s_axi_wready = ce && !wHeld && !s_axi_bvalid;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld <= 1'b0;
            awAddr <= 8'h00;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            else if (writeFire)
            begin
                awHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            else if (writeFire)
            begin
                wHeld <= 1'b0;
            end
        end
    end

    assign writeFire = ce && awHeld && wHeld && !s_axi_bvalid;
    assign writeOk = (awAddr[7:2] == `BSF_OFS_STATUS >> 2) || (awAddr[7:2] == `BSF_OFS_WORK >> 2)
        || (awAddr[7:2] == `BSF_OFS_IO >> 2) || (awAddr[7:2] == `BSF_OFS_CMD >> 2);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BSF_RESP_OKAY;
        end
        else if (ce)
        begin
            if (writeFire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= writeOk ? `BSF_RESP_OKAY : `BSF_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command launch
    assign cmdOp = bsf_bsf_cast(wData[`BSF_CMD_OP_LSB +: 5]);
    assign isIoCmd = (cmdOp == bsf_pkg::OP_IO_BIT_SET) || (cmdOp == bsf_pkg::OP_IO_BIT_CLEAR);
    assign cmdStart = writeFire && (state == bsf_pkg::ST_IDLE) && (awAddr == `BSF_OFS_CMD)
        && wStrb[0] && wStrb[1];
    assign commit = ce && (state == bsf_pkg::ST_EXEC) && (cycLeft == 1'b0);
    assign curIsIo = (curOp == bsf_pkg::OP_IO_BIT_SET) || (curOp == bsf_pkg::OP_IO_BIT_CLEAR);

    function automatic bsf_pkg::bsf_op_t bsf_bsf_cast(input logic [4:0] code);
        bsf_bsf_cast = bsf_pkg::bsf_op_t'(code);
    endfunction : bsf_bsf_cast

    // sequencer: io ops hold for a second cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= bsf_pkg::ST_IDLE;
            curOp <= bsf_pkg::OP_NOP;
            curBit <= 3'h0;
            cycLeft <= 1'b0;
        end
        else if (ce)
        begin
            unique case (state)
                bsf_pkg::ST_IDLE:
                begin
                    if (cmdStart)
                    begin
                        state <= bsf_pkg::ST_EXEC;
                        curOp <= cmdOp;
                        curBit <= wData[`BSF_CMD_BIT_LSB +: 3];
                        cycLeft <= isIoCmd ? 1'(`BSF_IO_OP_CYCLES - 1)
                            : 1'(`BSF_REG_OP_CYCLES - 1);
                    end
                end
                bsf_pkg::ST_EXEC:
                begin
                    if (cycLeft == 1'b0)
                    begin
                        state <= bsf_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cycLeft <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign aluBus.op = curOp;
    assign aluBus.operand = curIsIo ? ioReg : work;
    assign aluBus.bitSel = curBit;
    assign aluBus.flagsIn = flagReg;

    // data registers: software writes only while idle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            work <= `BSF_RST_WORK;
        end
        else if (commit && !curIsIo)
        begin
            work <= aluBus.result;
        end
        else if (writeFire && state == bsf_pkg::ST_IDLE && awAddr == `BSF_OFS_WORK && wStrb[0])
        begin
            work <= wData[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ioReg <= `BSF_RST_IO;
        end
        else if (commit && curIsIo)
        begin
            ioReg <= aluBus.result;
        end
        else if (writeFire && state == bsf_pkg::ST_IDLE && awAddr == `BSF_OFS_IO && wStrb[0])
        begin
            ioReg <= wData[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flagReg <= `BSF_RST_STATUS;
        end
        else if (commit)
        begin
            flagReg <= aluBus.flagsOut;
        end
        else if (writeFire && state == bsf_pkg::ST_IDLE && awAddr == `BSF_OFS_STATUS && wStrb[0])
        begin
            flagReg <= wData[7:0];
        end
    end

    assign statusFlags = flagReg;
    assign busy = (state == bsf_pkg::ST_EXEC);

    // read channel
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `BSF_RESP_OKAY;
        unique case (s_axi_araddr[7:2])
            6'(`BSF_OFS_STATUS >> 2): next_rdata[7:0] = flagReg;
            6'(`BSF_OFS_WORK >> 2): next_rdata[7:0] = work;
            6'(`BSF_OFS_IO >> 2): next_rdata[7:0] = ioReg;
            6'(`BSF_OFS_CMD >> 2):
            begin
                next_rdata[`BSF_CMD_OP_LSB +: 5] = curOp;
                next_rdata[`BSF_CMD_BIT_LSB +: 3] = curBit;
                next_rdata[`BSF_CMD_BUSY_POS] = busy;
            end
            default: next_rresp = `BSF_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BSF_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_io_set_bit: assert property (commit && curOp == bsf_pkg::OP_IO_BIT_SET |=>
        ioReg == ($past(ioReg) | (8'h01 << $past(curBit))) && flagReg == $past(flagReg))
        else $error("io bit set wrong");
    a_io_clear_bit: assert property (commit && curOp == bsf_pkg::OP_IO_BIT_CLEAR |=>
        ioReg == ($past(ioReg) & ~(8'h01 << $past(curBit))) && flagReg == $past(flagReg))
        else $error("io bit clear wrong");
    a_io_two_cycles: assert property (cmdStart && isIoCmd ##1 ce ##1 ce |=>
        state == bsf_pkg::ST_IDLE)
        else $error("io op not two cycles");
    a_reg_one_cycle: assert property (cmdStart && !isIoCmd ##1 ce |=>
        state == bsf_pkg::ST_IDLE)
        else $error("register op not one cycle");
    a_shift_left_flags: assert property (commit && curOp == bsf_pkg::OP_LOGICAL_LEFT_SHIFT |=>
        work == {$past(work[6:0]), 1'b0} && flagReg[`BSF_FLAG_C] == $past(work[7])
        && flagReg[`BSF_FLAG_Z] == (work == 8'h00))
        else $error("left shift wrong");
    a_shift_right: assert property (commit && curOp == bsf_pkg::OP_LOGICAL_RIGHT_SHIFT |=>
        work == {1'b0, $past(work[7:1])} && flagReg[`BSF_FLAG_N] == 1'b0
        && flagReg[`BSF_FLAG_V] == flagReg[`BSF_FLAG_C])
        else $error("right shift wrong");
    a_rotate_left: assert property (commit && curOp == bsf_pkg::OP_ROTATE_LEFT_CARRY |=>
        work[0] == $past(flagReg[`BSF_FLAG_C]) && flagReg[`BSF_FLAG_C] == $past(work[7]))
        else $error("rotate left wrong");
    a_rotate_right: assert property (commit && curOp == bsf_pkg::OP_ROTATE_RIGHT_CARRY |=>
        work[7] == $past(flagReg[`BSF_FLAG_C]) && flagReg[`BSF_FLAG_C] == $past(work[0]))
        else $error("rotate right wrong");
    a_arith_shift: assert property (commit && curOp == bsf_pkg::OP_ARITH_RIGHT_SHIFT |=>
        work == {$past(work[7]), $past(work[7:1])})
        else $error("arith shift wrong");
    a_nibble_swap: assert property (commit && curOp == bsf_pkg::OP_NIBBLE_SWAP |=>
        work == {$past(work[3:0]), $past(work[7:4])} && $stable(flagReg))
        else $error("swap wrong");
    a_bit_store: assert property (commit && curOp == bsf_pkg::OP_BIT_TO_TRANSFER |=>
        flagReg[`BSF_FLAG_T] == $past(work[curBit]) && (flagReg | 8'h40) == ($past(flagReg) | 8'h40))
        else $error("bit store wrong");
    a_bit_load: assert property (commit && curOp == bsf_pkg::OP_TRANSFER_TO_BIT |=>
        work[$past(curBit)] == flagReg[`BSF_FLAG_T] && $stable(flagReg))
        else $error("bit load wrong");
    a_indexed_set: assert property (commit && curOp == bsf_pkg::OP_INDEXED_FLAG_SET |=>
        flagReg == ($past(flagReg) | (8'h01 << $past(curBit))))
        else $error("indexed set wrong");
    a_indexed_clear: assert property (commit && curOp == bsf_pkg::OP_INDEXED_FLAG_CLEAR |=>
        flagReg == ($past(flagReg) & ~(8'h01 << $past(curBit))))
        else $error("indexed clear wrong");
    a_irq_enable: assert property (commit && curOp == bsf_pkg::OP_IRQ_ENABLE |=>
        flagReg == ($past(flagReg) | 8'h80))
        else $error("irq enable wrong");
    a_irq_disable: assert property (commit && curOp == bsf_pkg::OP_IRQ_DISABLE |=>
        flagReg == ($past(flagReg) & 8'h7f))
        else $error("irq disable wrong");

    c_io_op: cover property (commit && curIsIo);
    c_rotate: cover property (commit && curOp == bsf_pkg::OP_ROTATE_LEFT_CARRY);
    c_flag_clear: cover property (commit && curOp == bsf_pkg::OP_CARRY_CLEAR);
    c_read_status: cover property (s_axi_rvalid && s_axi_rready);
endmodule : bsf_unit

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "bsf_defs.svh"

module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [7:0] statusFlags;
    logic busy;
    int n_errors = 0;
    int comparisons = 0;
    int busyCnt = 0;
    logic [31:0] rdVal;
    logic [7:0] vals [5] = '{8'h81, 8'h01, 8'h80, 8'h00, 8'h7e};

    always #4 clk = ~clk;

    // busy cycles seen per command
    always @(negedge clk)
        if (busy === 1'b1)
            busyCnt <= busyCnt + 1;

    bsf_unit uut (.clk(clk), .reset_n(reset_n), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .statusFlags(statusFlags), .busy(busy));

    task final_report;
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task timeout;
        n_errors++;
        final_report();
    endtask : timeout

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ready is sampled at the falling edge, the handshake lands on the next rising edge
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        logic awDone, wDone, tA, tW, bDone;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        bDone = 1'b0;
        for (i = 0; i < 50 && !(awDone && wDone); i++)
        begin
            @(negedge clk);
            tA = !awDone && s_axi_awready === 1'b1;
            tW = !wDone && s_axi_wready === 1'b1;
            @(posedge clk);
            if (tA)
                s_axi_awvalid <= 1'b0;
            if (tW)
                s_axi_wvalid <= 1'b0;
            awDone = awDone || tA;
            wDone = wDone || tW;
        end
        if (!(awDone && wDone))
            timeout();
        for (i = 0; i < 50 && !bDone; i++)
        begin
            @(negedge clk);
            if (s_axi_bvalid === 1'b1)
            begin
                chk({30'h0, s_axi_bresp}, {30'h0, er});
                @(posedge clk);
                s_axi_bready <= 1'b0;
                bDone = 1'b1;
            end
        end
        if (!bDone)
            timeout();
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int i;
        logic arDone, rDone;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        arDone = 1'b0;
        rDone = 1'b0;
        for (i = 0; i < 50 && !arDone; i++)
        begin
            @(negedge clk);
            arDone = s_axi_arready === 1'b1;
            @(posedge clk);
            if (arDone)
                s_axi_arvalid <= 1'b0;
        end
        for (i = 0; i < 50 && !rDone && arDone; i++)
        begin
            @(negedge clk);
            if (s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                chk({30'h0, s_axi_rresp}, {30'h0, er});
                @(posedge clk);
                s_axi_rready <= 1'b0;
                rDone = 1'b1;
            end
        end
        if (!rDone)
            timeout();
    endtask : axi_read

    // expected {status, io, work} after one command
    function automatic logic [23:0] model(logic [4:0] op, logic [2:0] b, logic [7:0] w, logic [7:0] io,
        logic [7:0] st);
        logic [7:0] r;
        logic c;
        r = w;
        c = st[`BSF_FLAG_C];
        case (op)
            5'h01: io[b] = 1'b1;
            5'h02: io[b] = 1'b0;
            5'h03: {c, r} = {w, 1'b0};
            5'h04: {r, c} = {1'b0, w};
            5'h05: {c, r} = {w, st[`BSF_FLAG_C]};
            5'h06: {r, c} = {st[`BSF_FLAG_C], w};
            5'h07: {r, c} = {w[7], w};
            5'h08: r = {w[3:0], w[7:4]};
            5'h09: st[`BSF_FLAG_T] = w[b];
            5'h0a: r[b] = st[`BSF_FLAG_T];
            5'h0b: st[b] = 1'b1;
            5'h0c: st[b] = 1'b0;
            default: if (op >= 5'h10) st[op[2:0]] = !op[3];
        endcase
        if (op >= 5'h03 && op <= 5'h07)
        begin
            st[`BSF_FLAG_C] = c;
            st[`BSF_FLAG_Z] = r == 8'h00;
            st[`BSF_FLAG_N] = r[7];
            st[`BSF_FLAG_V] = r[7] ^ c;
        end
        return {st, io, r};
    endfunction : model

    task test_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] w, input logic [7:0] st,
        input logic [7:0] io);
        logic [23:0] e;
        int i;
        e = model(op, b, w, io, st);
        axi_write(`BSF_OFS_STATUS, {24'h0, st}, `BSF_RESP_OKAY);
        axi_write(`BSF_OFS_WORK, {24'h0, w}, `BSF_RESP_OKAY);
        axi_write(`BSF_OFS_IO, {24'h0, io}, `BSF_RESP_OKAY);
        busyCnt = 0;
        axi_write(`BSF_OFS_CMD, {21'h0, b, 3'h0, op}, `BSF_RESP_OKAY);
        for (i = 0; i < 20 && busy !== 1'b0; i++)
            @(negedge clk);
        if (busy !== 1'b0)
            timeout();
        chk(busyCnt, (op == 5'h01 || op == 5'h02) ? `BSF_IO_OP_CYCLES : `BSF_REG_OP_CYCLES);
        axi_read(`BSF_OFS_STATUS, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, e[23:16]});
        chk({24'h0, statusFlags}, {24'h0, e[23:16]});
        axi_read(`BSF_OFS_IO, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, e[15:8]});
        axi_read(`BSF_OFS_WORK, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, e[7:0]});
    endtask : test_op

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        axi_read(`BSF_OFS_STATUS, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, `BSF_RST_STATUS});
        axi_read(`BSF_OFS_WORK, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, `BSF_RST_WORK});
        axi_read(`BSF_OFS_IO, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, {24'h0, `BSF_RST_IO});
        axi_read(8'h10, rdVal, `BSF_RESP_SLVERR);
        chk(rdVal, 32'h0);
        axi_write(8'h14, 32'hff, `BSF_RESP_SLVERR);
        // shifts, rotates and swap, each with carry in low and high
        for (int v = 0; v < 5; v++)
            for (int op = 3; op <= 8; op++)
                for (int cin = 0; cin < 2; cin++)
                    test_op(5'(op), 3'h0, vals[v], (cin != 0) ? 8'hb1 : 8'h6e, 8'h00);
        // single-bit operations across every bit index
        for (int b = 0; b < 8; b++)
        begin
            test_op(5'h01, 3'(b), 8'h00, 8'h00, 8'h5a);
            test_op(5'h02, 3'(b), 8'h00, 8'hff, 8'ha5);
            test_op(5'h09, 3'(b), 8'h5a, b[0] ? 8'h40 : 8'hbf, 8'h00);
            test_op(5'h0a, 3'(b), 8'h5a, b[0] ? 8'h40 : 8'hbf, 8'h00);
            test_op(5'h0b, 3'(b), 8'h00, 8'h00, 8'h00);
            test_op(5'h0c, 3'(b), 8'h00, 8'hff, 8'h00);
        end
        // dedicated flag set and clear, interrupt enable and disable
        for (int op = 16; op < 32; op++)
        begin
            test_op(5'(op), 3'h0, 8'h3c, 8'h00, 8'h00);
            test_op(5'(op), 3'h0, 8'h3c, 8'hff, 8'h00);
        end
        // clock enable low holds an io op in flight
        axi_write(`BSF_OFS_IO, 32'h0000_0011, `BSF_RESP_OKAY);
        axi_write(`BSF_OFS_CMD, 32'h0000_0301, `BSF_RESP_OKAY);
        ce <= 1'b0;
        repeat (4) @(negedge clk);
        chk({31'h0, busy}, 32'h1);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(negedge clk);
        chk({31'h0, busy}, 32'h0);
        axi_read(`BSF_OFS_IO, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, 32'h0000_0019);
        test_op(5'h0a, 3'h5, 8'h00, 8'h40, 8'h00);
        axi_read(`BSF_OFS_CMD, rdVal, `BSF_RESP_OKAY);
        chk(rdVal, 32'h0000050a);
        final_report();
    end
endmodule : testbench
